// ### tcr_pkg.sv
// Function
// - three phases: die, thermocouple, fault check
// - die phase: cold-junction and ground closed
// - thermocouple phase: ground and converter closed
// - fault phase: only fault switches closed
// - separate flags for supply, ground, open
// - flags sit at frame bits two to zero
// - fault bit is OR of three flags
// - conversions run during serial activity until the fifo fills
// - frame updates only while select high
// - sign bit driven as select falls
// - bits shift out on falling serial clock
// - select may rise anytime; transfer ends cleanly
// - open input reads sign zero, rest ones
// - top fourteen bits: compensated quarter-degree temperature
// - bits fifteen to four: die temperature
// - reserved bits seventeen and three read zero
// - die measured before thermocouple voltage
// - signed sum of thermocouple and die
// - select active low enables interface
`default_nettype none
package tcr_pkg;
    localparam int FRAME_W = 32;
    localparam int TC_W = 14;
    localparam int DIE_W = 12;
    localparam int ADC_W = 14;
    // die step is a quarter of the thermocouple step
    localparam int DIE_SHIFT = 2;
    localparam int CLK_PERIOD_NS = 10;
    // longest select-to-data time, rounded down
    localparam int SEL_DELAY_NS = 100;
    localparam int SEL_DELAY_CYC = (SEL_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 : SEL_DELAY_NS / CLK_PERIOD_NS;
    // settling time of the fault comparators, rounded up
    localparam int FAULT_SETTLE_NS = 2000;
    localparam int FAULT_SETTLE_CYC = (FAULT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 16;
    // frame bit positions
    localparam int BIT_SIGN = 31;
    localparam int BIT_TC_LSB = 18;
    localparam int BIT_RSV_HI = 17;
    localparam int BIT_FAULT = 16;
    localparam int BIT_DIE_LSB = 4;
    localparam int BIT_RSV_LO = 3;
    localparam int BIT_SCV = 2;
    localparam int BIT_SCG = 1;
    localparam int BIT_OC = 0;
    localparam logic [TC_W-1:0] TC_OPEN_CODE = 14'h1fff;
    // synchroniser slots: select, serial clock, three comparators
    localparam int SY_CS = 0;
    localparam int SY_SCK = 1;
    localparam int SY_VCC = 2;
    localparam int SY_GND = 3;
    localparam int SY_OPEN = 4;
    localparam int SY_N = 5;
    localparam logic [SY_N-1:0] SYNC_RST = 5'h01;

    typedef struct packed {
        logic fault_detect_switch_a;
        logic fault_detect_switch_b;
        logic ground_reference_switch;
        logic thermocouple_adc_switch;
        logic cold_junction_switch;
    } tcr_sw_t;

    localparam tcr_sw_t SW_OFF = 5'h00;
    localparam tcr_sw_t SW_DIE = 5'h05;
    localparam tcr_sw_t SW_TC = 5'h06;
    localparam tcr_sw_t SW_FLT = 5'h18;

    typedef struct packed {
        logic [TC_W-1:0] tc;
        logic [DIE_W-1:0] die;
        logic short_to_supply_flag;
        logic short_to_ground_flag;
        logic open_circuit_flag;
    } tcr_result_t;

    localparam tcr_result_t RESULT_RST = '0;
endpackage
`default_nettype wire

// ### tcr_readout.sv
`timescale 1ns/1ps
`default_nettype none

// small flop-based fifo, width and depth as parameters
module tcr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire empty = (wr_r == rd_r);
    wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);

    // honest flags straight from the pointers
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_r[rd_r[AW-1:0]];

    // pointer update
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push)
                wr_r <= wr_r + 1'b1;
            if (pop)
                rd_r <= rd_r + 1'b1;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (push)
            mem_r[wr_r[AW-1:0]] <= in_data;
    end
endmodule

module tcr_readout #(
    parameter int FAULT_SETTLE = tcr_pkg::FAULT_SETTLE_CYC,
    parameter int DEPTH = tcr_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // serial pins, select active low
    input wire logic cs_n,
    input wire logic sck,
    output logic so_data,
    output logic so_oe,
    // converter handshake
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [tcr_pkg::ADC_W-1:0] adc_result,
    // fault comparator levels, asynchronous
    input wire logic cmp_short_vcc,
    input wire logic cmp_short_gnd,
    input wire logic cmp_open,
    // analog switch controls
    output tcr_pkg::tcr_sw_t sw_ctrl
);
    localparam int SEL_CYC = tcr_pkg::SEL_DELAY_CYC;
    localparam int CW = $clog2(FAULT_SETTLE + 1);
    localparam int RW = $bits(tcr_pkg::tcr_result_t);

    typedef enum logic [2:0] {
        ST_DIE_START,
        ST_DIE_WAIT,
        ST_TC_START,
        ST_TC_WAIT,
        ST_FLT,
        ST_PUSH
    } tcr_state_t;

    tcr_state_t st_r;
    tcr_state_t st_nxt;
    tcr_pkg::tcr_sw_t sw_r;
    tcr_pkg::tcr_sw_t sw_nxt;
    logic [CW-1:0] cnt_r;
    logic [tcr_pkg::DIE_W-1:0] die_r;
    logic [tcr_pkg::TC_W-1:0] tc_raw_r;
    logic [2:0] flt_r;
    logic [tcr_pkg::SY_N-1:0] s1_r;
    logic [tcr_pkg::SY_N-1:0] s2_r;
    logic sck_d_r;
    logic [tcr_pkg::FRAME_W-1:0] shift_r;
    tcr_pkg::tcr_result_t lat_r;
    tcr_pkg::tcr_result_t lat_nxt;
    tcr_pkg::tcr_result_t res;
    tcr_pkg::tcr_result_t fifo_out;
    logic [RW-1:0] fifo_out_bits;
    logic fifo_in_ready;
    logic fifo_out_valid;

    // two flops on select, serial clock and each comparator level
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s1_r <= tcr_pkg::SYNC_RST;
            s2_r <= tcr_pkg::SYNC_RST;
            sck_d_r <= 1'b0;
        end else begin
            s1_r <= {cmp_open, cmp_short_gnd, cmp_short_vcc, sck, cs_n};
            s2_r <= s1_r;
            sck_d_r <= s2_r[tcr_pkg::SY_SCK];
        end
    end

    // select is active low; interface live only while it is low
    wire cs_high = s2_r[tcr_pkg::SY_CS];
    wire sck_fall = sck_d_r && !s2_r[tcr_pkg::SY_SCK];

    // sequencer: die, thermocouple, fault, then hand off result
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_DIE_START: st_nxt = ST_DIE_WAIT;
            ST_DIE_WAIT: if (adc_done) st_nxt = ST_TC_START;
            ST_TC_START: st_nxt = ST_TC_WAIT;
            ST_TC_WAIT: if (adc_done) st_nxt = ST_FLT;
            ST_FLT: if (cnt_r == CW'(FAULT_SETTLE - 1)) st_nxt = ST_PUSH;
            // only a full fifo stalls; it fills while select is held low
            ST_PUSH: if (fifo_in_ready) st_nxt = ST_DIE_START;
            default: st_nxt = ST_DIE_START;
        endcase
    end

    // switch set follows the phase being entered
    always_comb begin
        case (st_nxt)
            ST_DIE_START, ST_DIE_WAIT: sw_nxt = tcr_pkg::SW_DIE;
            ST_TC_START, ST_TC_WAIT: sw_nxt = tcr_pkg::SW_TC;
            ST_FLT: sw_nxt = tcr_pkg::SW_FLT;
            default: sw_nxt = tcr_pkg::SW_OFF;
        endcase
    end

    assign sw_ctrl = sw_r;
    assign adc_start = (st_r == ST_DIE_START) || (st_r == ST_TC_START);

    // phase state and settle counter
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= ST_DIE_START;
            sw_r <= tcr_pkg::SW_DIE; // reset state already starts a die conversion
            cnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            sw_r <= sw_nxt;
            cnt_r <= (st_r == ST_FLT) ? cnt_r + 1'b1 : '0;
        end
    end

    // converter and comparator captures
    always_ff @(posedge core_clk) begin
        if (reset) begin
            die_r <= '0;
            tc_raw_r <= '0;
            flt_r <= '0;
        end else begin
            if (st_r == ST_DIE_WAIT && adc_done)
                die_r <= adc_result[tcr_pkg::DIE_W-1:0];
            if (st_r == ST_TC_WAIT && adc_done)
                tc_raw_r <= adc_result;
            // one flag per condition, sampled after settling
            if (st_nxt == ST_PUSH && st_r == ST_FLT)
                flt_r <= s2_r[tcr_pkg::SY_OPEN:tcr_pkg::SY_VCC];
        end
    end

    // die to quarter-degree steps, sign kept for cold ends below zero
    wire [tcr_pkg::TC_W-1:0] die_q = {{(tcr_pkg::TC_W - tcr_pkg::DIE_W + tcr_pkg::DIE_SHIFT){die_r[tcr_pkg::DIE_W-1]}},
        die_r[tcr_pkg::DIE_W-1:tcr_pkg::DIE_SHIFT]};
    wire [tcr_pkg::TC_W-1:0] tc_sum = tc_raw_r + die_q;
    wire open_now = flt_r[2];

    // result word; an open input forces the fixed open code
    always_comb begin
        res.tc = open_now ? tcr_pkg::TC_OPEN_CODE : tc_sum;
        res.die = die_r;
        res.short_to_supply_flag = flt_r[0];
        res.short_to_ground_flag = flt_r[1];
        res.open_circuit_flag = open_now;
    end

    tcr_fifo #(
        .W(RW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(core_clk),
        .reset(reset),
        .in_valid(st_r == ST_PUSH),
        .in_ready(fifo_in_ready),
        .in_data(res),
        .out_valid(fifo_out_valid),
        .out_ready(cs_high),
        .out_data(fifo_out_bits)
    );

    assign fifo_out = fifo_out_bits;
    // drain only with select high so a read sees one frozen frame
    assign lat_nxt = (fifo_out_valid && cs_high) ? fifo_out : lat_r;

    // frame layout: temp, reserved, fault, die, reserved, flags
    wire fault_any = lat_nxt.short_to_supply_flag | lat_nxt.short_to_ground_flag |
        lat_nxt.open_circuit_flag;
    wire [tcr_pkg::FRAME_W-1:0] frame_nxt = {lat_nxt.tc, 1'b0, fault_any, lat_nxt.die, 1'b0,
        lat_nxt.short_to_supply_flag, lat_nxt.short_to_ground_flag,
        lat_nxt.open_circuit_flag};

    // latch and shifter; reload while deselected ends any partial read
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lat_r <= tcr_pkg::RESULT_RST;
            shift_r <= '0;
        end else begin
            lat_r <= lat_nxt;
            if (cs_high)
                shift_r <= frame_nxt;
            else if (sck_fall)
                shift_r <= {shift_r[tcr_pkg::FRAME_W-2:0], 1'b0};
        end
    end

    // sign bit already waits in the top of the shifter
    assign so_data = shift_r[tcr_pkg::BIT_SIGN];
    assign so_oe = !cs_high;

    sequence s_die_done;
        st_r == ST_DIE_WAIT && adc_done;
    endsequence

    sequence s_tc_run;
        st_r == ST_TC_START ##1 st_r == ST_TC_WAIT;
    endsequence

    a_phase_order: assert property (@(posedge core_clk) disable iff (reset)
        s_die_done |=> s_tc_run)
        else $error("thermocouple phase did not follow die phase");

    a_die_switches: assert property (@(posedge core_clk) disable iff (reset)
        (st_r == ST_DIE_START || st_r == ST_DIE_WAIT) |-> sw_ctrl == tcr_pkg::SW_DIE)
        else $error("wrong switch set in die phase");

    a_tc_switches: assert property (@(posedge core_clk) disable iff (reset)
        (st_r == ST_TC_WAIT) |-> sw_ctrl == tcr_pkg::SW_TC)
        else $error("wrong switch set in thermocouple phase");

    a_flt_switches: assert property (@(posedge core_clk) disable iff (reset)
        (st_r == ST_FLT) |-> sw_ctrl == tcr_pkg::SW_FLT)
        else $error("wrong switch set in fault phase");

    a_fault_or: assert property (@(posedge core_clk) disable iff (reset)
        cs_high |=> shift_r[tcr_pkg::BIT_FAULT] ==
        (lat_r.short_to_supply_flag | lat_r.short_to_ground_flag | lat_r.open_circuit_flag))
        else $error("fault bit does not match flags");

    a_reserved_zero: assert property (@(posedge core_clk) disable iff (reset)
        cs_high |=> !shift_r[tcr_pkg::BIT_RSV_HI] && !shift_r[tcr_pkg::BIT_RSV_LO])
        else $error("reserved frame bit set");

    a_hold_frame: assert property (@(posedge core_clk) disable iff (reset)
        !cs_high |=> $stable(lat_r))
        else $error("frame changed during read");

    a_shift_fall: assert property (@(posedge core_clk) disable iff (reset)
        !cs_high && sck_fall |=> shift_r == {$past(shift_r[tcr_pkg::FRAME_W-2:0]), 1'b0})
        else $error("shifter did not advance on falling clock");

    a_first_bit: assert property (@(posedge core_clk) disable iff (reset)
        $fell(cs_high) |-> so_data == lat_r.tc[tcr_pkg::TC_W-1])
        else $error("sign bit missing at select fall");

    a_sel_delay: assert property (@(posedge core_clk) disable iff (reset)
        $fell(cs_n) |-> ##[1:SEL_CYC] (so_oe || cs_n))
        else $error("output not enabled in time after select");

    a_release: assert property (@(posedge core_clk) disable iff (reset)
        cs_high |-> !so_oe)
        else $error("output driven while deselected");

    a_open_code: assert property (@(posedge core_clk) disable iff (reset)
        (st_r == ST_PUSH && flt_r[2]) |-> res.tc == tcr_pkg::TC_OPEN_CODE)
        else $error("open input does not give open code");

    a_compensate: assert property (@(posedge core_clk) disable iff (reset)
        (st_r == ST_PUSH && !flt_r[2]) |->
        $signed(res.tc) == $signed(tc_raw_r) + ($signed(die_r) >>> tcr_pkg::DIE_SHIFT))
        else $error("compensated sum wrong");

    a_flag_sample: assert property (@(posedge core_clk) disable iff (reset)
        (st_r == ST_FLT && st_nxt == ST_PUSH) |=> flt_r == $past(s2_r[tcr_pkg::SY_OPEN:tcr_pkg::SY_VCC]))
        else $error("fault flags not captured");

    a_flag_bits: assert property (@(posedge core_clk) disable iff (reset)
        cs_high |=> shift_r[tcr_pkg::BIT_OC] == lat_r.open_circuit_flag &&
        shift_r[tcr_pkg::BIT_SCG] == lat_r.short_to_ground_flag &&
        shift_r[tcr_pkg::BIT_SCV] == lat_r.short_to_supply_flag)
        else $error("flag bits misplaced");
endmodule

`default_nettype wire

// ### tcr_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module tcr_far_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // serial pins
    output logic cs_n,
    output logic sck,
    input wire logic so_wire,
    // converter handshake
    input wire logic adc_start,
    output logic adc_done,
    output logic [tcr_pkg::ADC_W-1:0] adc_result,
    input wire tcr_pkg::tcr_sw_t sw_ctrl,
    // codes the converter hands back
    input wire logic [tcr_pkg::DIE_W-1:0] die_code,
    input wire logic [tcr_pkg::TC_W-1:0] tc_code
);
    logic done_r = 1'b0;
    logic [tcr_pkg::ADC_W-1:0] res_r = '0;
    logic busy_r = 1'b0;
    logic slow_r = 1'b0;
    int cnt_r = 0;

    assign adc_done = done_r;
    assign adc_result = res_r;

    // select high and clock low while idle
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
    end

    // converter: latency alternates short and long so both paths get exercised
    always @(posedge core_clk) begin
        done_r <= 1'b0;
        if (reset) begin
            busy_r <= 1'b0;
            slow_r <= 1'b0;
        end else if (adc_start) begin
            busy_r <= 1'b1;
            cnt_r <= slow_r ? 9 : 1;
            slow_r <= !slow_r;
            // cold-junction switch closed marks the die phase
            res_r <= sw_ctrl.cold_junction_switch ? {{2{die_code[11]}}, die_code} : tc_code;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 1;
            if (cnt_r == 0) begin
                done_r <= 1'b1;
                busy_r <= 1'b0;
            end
        end
    end

    // host read: bits taken on rising sck, clock stands still outside frames
    task automatic read_frame(input int n, output logic [31:0] data);
        data = '0;
        @(posedge core_clk);
        cs_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            data = {data[30:0], so_wire};
            sck <= 1'b1;
            repeat (8) @(posedge core_clk);
            sck <= 1'b0;
            repeat (8) @(posedge core_clk);
        end
        repeat (10) @(posedge core_clk);
        cs_n <= 1'b1;
        repeat (20) @(posedge core_clk);
    endtask
endmodule

`default_nettype wire

// ### tcr_readout_bench.sv
`timescale 1ns/1ps
`default_nettype none

module tcr_readout_bench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cmp_short_vcc = 1'b0;
    logic cmp_short_gnd = 1'b0;
    logic cmp_open = 1'b0;
    logic [11:0] die_code = 12'h000;
    logic [13:0] tc_code = 14'h0000;
    logic cs_n, sck, so_data, so_oe, adc_start, adc_done;
    logic [13:0] adc_result;
    tcr_pkg::tcr_sw_t sw_ctrl;
    wire so_wire;
    int errors = 0;
    int samples_checked = 0;
    logic [31:0] rd;

    // shared line floats whenever the device lets go
    assign so_wire = so_oe ? so_data : 1'bz;

    tcr_readout #(.FAULT_SETTLE(4), .DEPTH(16)) dut (
        .core_clk(core_clk), .reset(reset), .cs_n(cs_n), .sck(sck), .so_data(so_data), .so_oe(so_oe),
        .adc_start(adc_start), .adc_done(adc_done), .adc_result(adc_result), .cmp_short_vcc(cmp_short_vcc),
        .cmp_short_gnd(cmp_short_gnd), .cmp_open(cmp_open), .sw_ctrl(sw_ctrl));

    tcr_far_model far (
        .core_clk(core_clk), .reset(reset), .cs_n(cs_n), .sck(sck), .so_wire(so_wire),
        .adc_start(adc_start), .adc_done(adc_done), .adc_result(adc_result), .sw_ctrl(sw_ctrl),
        .die_code(die_code), .tc_code(tc_code));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic summarize();
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_sw(input string what, input tcr_pkg::tcr_sw_t exp, input tcr_pkg::tcr_sw_t got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    // frame worked out independently: die scaled to quarter degrees, signed add
    function automatic logic [31:0] exp_frame(input logic [11:0] d, input logic [13:0] t, input logic [2:0] f);
        logic [13:0] sum;
        sum = t + {{4{d[11]}}, d[11:2]};
        if (f[0]) sum = 14'h1fff;
        return {sum, 1'b0, |f, d, 1'b0, f};
    endfunction

    task automatic set_vals(input logic [11:0] d, input logic [13:0] t, input logic [2:0] f);
        @(posedge core_clk);
        die_code <= d;
        tc_code <= t;
        {cmp_short_vcc, cmp_short_gnd, cmp_open} <= f;
        repeat (80) @(posedge core_clk);
    endtask

    // bounded wait for the converter start pulse
    task automatic wait_start();
        int n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (adc_start !== 1'b1 && n < 300);
        if (n >= 300) begin
            errors++;
            summarize();
        end
    endtask

    task automatic t_phases();
        int n = 0;
        // align on a fault phase first; the die start right after reset is over before this task runs
        while (sw_ctrl !== tcr_pkg::SW_FLT && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        wait_start();
        check_sw("die switches", tcr_pkg::SW_DIE, sw_ctrl);
        wait_start();
        check_sw("tc switches", tcr_pkg::SW_TC, sw_ctrl);
        n = 0;
        while (sw_ctrl !== tcr_pkg::SW_FLT && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        check_sw("fault switches", tcr_pkg::SW_FLT, sw_ctrl);
    endtask

    task automatic t_values();
        logic [11:0] d[5] = '{12'h190, 12'hec0, 12'h649, 12'h000, 12'hfff};
        logic [13:0] t[5] = '{14'h0064, 14'h0004, 14'h3fe0, 14'h0010, 14'h0000};
        logic [2:0] f[5] = '{3'b000, 3'b000, 3'b100, 3'b010, 3'b001};
        for (int i = 0; i < 5; i++) begin
            set_vals(d[i], t[i], f[i]);
            far.read_frame(32, rd);
            check_word("full frame", exp_frame(d[i], t[i], f[i]), rd);
        end
    endtask

    task automatic t_short();
        logic [31:0] e;
        e = exp_frame(12'h190, 14'h0123, 3'b000);
        set_vals(12'h190, 14'h0123, 3'b000);
        far.read_frame(14, rd);
        check_word("temp only", {18'h0, e[31:18]}, rd);
        far.read_frame(5, rd);
        check_word("cut short", {27'h0, e[31:27]}, rd);
        far.read_frame(32, rd);
        check_word("read after cut", e, rd);
    endtask

    // inputs change mid-read; the queue fills while select is low
    task automatic t_hold();
        int starts = 0;
        logic [31:0] e;
        e = exp_frame(12'h050, 14'h0200, 3'b000);
        set_vals(12'h050, 14'h0200, 3'b000);
        fork
            far.read_frame(32, rd);
            begin
                repeat (30) @(posedge core_clk);
                set_vals(12'h7f0, 14'h1000, 3'b110);
                repeat (200) begin
                    @(posedge core_clk);
                    starts += int'(adc_start === 1'b1);
                end
            end
        join
        check_word("frame held", e, rd);
        check_bit("conversions while selected", 1'b1, starts > 4);
        repeat (80) @(posedge core_clk);
        far.read_frame(32, rd);
        check_word("frame after release", exp_frame(12'h7f0, 14'h1000, 3'b110), rd);
    endtask

    task automatic t_release();
        logic [31:0] e;
        e = exp_frame(12'h7f0, 14'h1000, 3'b110);
        check_bit("line idle", 1'bz, so_wire);
        fork
            far.read_frame(1, rd);
            begin
                repeat (6) @(posedge core_clk);
                check_bit("first bit", e[31], so_wire);
            end
        join
        check_bit("line after deselect", 1'bz, so_wire);
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        check_sw("switches in reset", tcr_pkg::SW_DIE, sw_ctrl);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_phases();
        t_values();
        t_short();
        t_hold();
        t_release();
        summarize();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge core_clk);
        errors++;
        summarize();
    end
endmodule

`default_nettype wire
